// File: smr_pkg.sv
// package: register map, fields, reset values and codes of the supply monitor registers
package smr_pkg;
	// register offsets (printed offsets are not all multiples of four: index, byte = 4*index)
	localparam logic [3:0] IDX_MODE_CTRL   = 4'h0;
	localparam logic [3:0] IDX_LEVEL_SEL   = 4'h1;
	localparam logic [3:0] IDX_MARGIN_CTRL = 4'h8;
	localparam logic [3:0] IDX_IRQ_CTRL    = 4'h9;
	localparam logic [3:0] IDX_IRQ_FLAGS   = 4'hA;
	localparam logic [3:0] IDX_STATUS      = 4'hB;
	localparam logic [3:0] IDX_UNLOCK      = 4'hC;
	// field positions
	localparam int POS_SLEEP_MODE  = 0;
	localparam int POS_ACTIVE_MODE = 2;
	localparam int POS_SAMP_RATE   = 4;
	localparam int POS_EDGE_SEL    = 1;
	localparam int POS_IRQ_EN      = 0;
	// reset values
	localparam logic [7:0] RST_MARGIN_CTRL = 8'h00;
	localparam logic [7:0] RST_IRQ_CTRL    = 8'h00;
	// unlock key and window (instructions approximated as bus writes)
	localparam logic [7:0] IO_REGISTER_UNLOCK_KEY = 8'hD8;
	localparam logic [2:0] UNLOCK_WINDOW          = 3'h4;
	// detector modes
	localparam logic [1:0] MODE_OFF        = 2'h0;
	localparam logic [1:0] MODE_CONTINUOUS = 2'h1;
	localparam logic [1:0] MODE_SAMPLED    = 2'h2;
	localparam logic [1:0] MODE_CONT_HOLD  = 2'h3;
	// edge selections
	localparam logic [1:0] EDGE_FALLING = 2'h0;
	localparam logic [1:0] EDGE_RISING  = 2'h1;
	localparam logic [1:0] EDGE_BOTH    = 2'h2;
	// sampling rates
	localparam int RATE_FAST_HZ = 128;
	localparam int RATE_SLOW_HZ = 32;
	typedef enum logic [1:0] {
		SMR_AWAKE  = 2'b01,
		SMR_ASLEEP = 2'b10
	} smr_pwr_t;
endpackage

// File: smr_supply_monitor_regs.sv
// supply monitor register block: apb slave, detector mode control, warning interrupt
// What this block does
// R1: one-bit read-only sampling rate, 0 is 128 Hz, 1 is 32 Hz, fuse reset.
// R2: two-bit read-only active mode field, reset from fuse.
// R3: active mode 0 off, 1/3 continuous; 3 holds execution until detector runs.
// R4: two-bit writable sleep mode field, reset from fuse.
// R5: sleep mode 0 off, 1 continuous, 2 sampled, 3 reserved.
// R6: three-bit read-only threshold level from fuse, codes above 3 reserved.
// R7: two-bit margin field, 0 monitor off, 1..3 give 5, 15, 25 percent.
// R8: two-bit edge select: falling, rising, both; 3 reserved.
// R9: interrupt control bit 0 enables the warning interrupt.
// R10: flag sets on a crossing matching the edge selection.
// R11: flag updates only while the detector is enabled.
// R12: status bit 0 is 1 while supply is below the warning threshold.
// R13: software ignores the status bit while the detector is off.
// R14: sleep field writes need the unlock key within four writes before.
// R15: sleep field applies in deep sleep, active field on wake.
// R16: monitor follows detector mode, off when off, sampled when sampled.
// R17: interrupt request while enable and flag both set, until flag cleared.
// R18: writing one clears the flag, zero leaves it.
// R19: below indication is synchronised; crossings from consecutive samples.
//
// Local design decision: the APB slave port.
`timescale 1ns/100ps
module smr_supply_monitor_regs (
	// clock and reset
	input  wire logic        core_clk_in,
	input  wire logic        rst_in,
	// apb slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	input  wire logic [3:0]  pstrb_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// fuse configuration, stable after reset release
	input  wire logic        fuse_samp_rate_in,
	input  wire logic [1:0]  fuse_active_mode_in,
	input  wire logic [1:0]  fuse_sleep_mode_in,
	input  wire logic [2:0]  fuse_level_in,
	// power state and analog side
	input  wire logic        deep_sleep_in,
	input  wire logic        below_threshold_in,
	input  wire logic        detector_running_in,
	// detector control to analog side
	output logic      [1:0]  detector_mode_out,
	output logic             detector_sampled_out,
	output logic             sampling_rate_sel_out,
	output logic      [2:0]  threshold_level_out,
	output logic      [1:0]  warning_margin_out,
	output logic             monitor_enable_out,
	output logic             continuous_hold_on_wake_out,
	// interrupt
	output logic             irq_out
);
	logic       sampling_rate_sel;
	logic [1:0] active_mode;
	logic [1:0] sleep_mode;
	logic [2:0] threshold_level;
	logic [1:0] warning_margin;
	logic [1:0] warning_edge_sel;
	logic       warning_irq_en;
	logic       warning_irq_flag;
	logic       below_meta;
	logic       below_sync;
	logic       below_prev;
	logic [2:0] unlock_count;
	logic       fuse_loaded;
	logic       hold_exec;
	smr_pkg::smr_pwr_t pwr_state;
	smr_pkg::smr_pwr_t next_pwr_state;

	// bus decode
	wire        access_done = psel_in && penable_in;
	wire        wr_done     = access_done && pwrite_in && pstrb_in[0];
	wire [3:0]  reg_idx     = paddr_in[5:2];
	wire        mapped      = (paddr_in[7:6] == 2'h0) && (paddr_in[1:0] == 2'h0) &&
		(reg_idx <= smr_pkg::IDX_UNLOCK) && !((reg_idx > smr_pkg::IDX_LEVEL_SEL) &&
		(reg_idx < smr_pkg::IDX_MARGIN_CTRL));
	wire        wr_mode     = wr_done && mapped && (reg_idx == smr_pkg::IDX_MODE_CTRL);
	wire        wr_margin   = wr_done && mapped && (reg_idx == smr_pkg::IDX_MARGIN_CTRL);
	wire        wr_irqctl   = wr_done && mapped && (reg_idx == smr_pkg::IDX_IRQ_CTRL);
	wire        wr_flags    = wr_done && mapped && (reg_idx == smr_pkg::IDX_IRQ_FLAGS);
	wire        wr_unlock   = wr_done && mapped && (reg_idx == smr_pkg::IDX_UNLOCK);
	wire        key_ok      = wr_unlock && (pwdata_in[7:0] == smr_pkg::IO_REGISTER_UNLOCK_KEY);
	wire        unlocked    = (unlock_count != 3'h0);
	wire [1:0]  wr_sleep    = pwdata_in[smr_pkg::POS_SLEEP_MODE +: 2];

	// effective detector mode and monitor enable
	wire [1:0]  eff_mode    = (pwr_state == smr_pkg::SMR_ASLEEP) ? sleep_mode : active_mode; // [R15]
	wire        det_on      = (eff_mode != smr_pkg::MODE_OFF); // [R16]
	wire        mon_on      = det_on && (warning_margin != 2'h0); // [R7] [R16]
	wire        fell        = below_sync && !below_prev; // [R19]
	wire        rose        = !below_sync && below_prev; // [R19]
	wire        edge_hit    = edge_match(warning_edge_sel, fell, rose); // [R8] [R10]
	wire        flag_set    = mon_on && edge_hit; // [R11]

	function automatic logic edge_match(input logic [1:0] sel, input logic f, input logic r);
		case (sel)
			smr_pkg::EDGE_FALLING: edge_match = f;
			smr_pkg::EDGE_RISING:  edge_match = r;
			smr_pkg::EDGE_BOTH:    edge_match = f || r;
			default:               edge_match = 1'b0;
		endcase
	endfunction

	// read mux
	logic [7:0] rd_byte;
	always_comb begin
		rd_byte = 8'h00;
		case (reg_idx)
			smr_pkg::IDX_MODE_CTRL:   rd_byte = {3'h0, sampling_rate_sel, active_mode, sleep_mode};
			smr_pkg::IDX_LEVEL_SEL:   rd_byte = {5'h00, threshold_level}; // [R6]
			smr_pkg::IDX_MARGIN_CTRL: rd_byte = {6'h00, warning_margin};
			smr_pkg::IDX_IRQ_CTRL:    rd_byte = {5'h00, warning_edge_sel, warning_irq_en};
			smr_pkg::IDX_IRQ_FLAGS:   rd_byte = {7'h00, warning_irq_flag};
			smr_pkg::IDX_STATUS:      rd_byte = {7'h00, below_sync}; // [R12] [R13]
			smr_pkg::IDX_UNLOCK:      rd_byte = {5'h00, unlock_count};
			default:                  rd_byte = 8'h00;
		endcase
	end

	assign pready_out  = 1'b1;
	assign pslverr_out = access_done && !mapped;

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			prdata_out <= 32'h0000_0000;
		end else if (psel_in && !penable_in && !pwrite_in && mapped) begin
			prdata_out <= {24'h00_0000, rd_byte};
		end else if (psel_in && !penable_in) begin
			prdata_out <= 32'h0000_0000;
		end
	end

	// fuse capture on the first clock after reset release
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			fuse_loaded <= 1'b0;
		end else begin
			fuse_loaded <= 1'b1;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			sampling_rate_sel <= 1'b0;
			active_mode       <= smr_pkg::MODE_OFF;
			threshold_level   <= 3'h0;
		end else if (!fuse_loaded) begin
			sampling_rate_sel <= fuse_samp_rate_in; // [R1]
			active_mode       <= fuse_active_mode_in; // [R2]
			threshold_level   <= fuse_level_in; // [R6]
		end
	end

	// protected sleep field: fuse value, then writes only inside the unlock window
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			sleep_mode <= smr_pkg::MODE_OFF;
		end else if (!fuse_loaded) begin
			sleep_mode <= fuse_sleep_mode_in; // [R4]
		end else if (wr_mode && unlocked && (wr_sleep != smr_pkg::MODE_CONT_HOLD)) begin
			sleep_mode <= wr_sleep; // [R14] [R5]
		end
	end

	// unlock window counts down on every bus write other than the key and mode writes
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			unlock_count <= 3'h0;
		end else if (key_ok) begin
			unlock_count <= smr_pkg::UNLOCK_WINDOW; // [R14]
		end else if (wr_mode) begin
			unlock_count <= 3'h0;
		end else if (wr_done && unlocked) begin
			unlock_count <= unlock_count - 3'h1;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			warning_margin   <= smr_pkg::RST_MARGIN_CTRL[1:0];
			warning_edge_sel <= smr_pkg::RST_IRQ_CTRL[2:1];
			warning_irq_en   <= smr_pkg::RST_IRQ_CTRL[0];
		end else begin
			if (wr_margin) begin
				warning_margin <= pwdata_in[1:0]; // [R7]
			end
			if (wr_irqctl) begin
				warning_edge_sel <= pwdata_in[smr_pkg::POS_EDGE_SEL +: 2]; // [R8]
				warning_irq_en   <= pwdata_in[smr_pkg::POS_IRQ_EN]; // [R9]
			end
		end
	end

	// warning flag: hardware set wins over write-one clear
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			warning_irq_flag <= 1'b0;
		end else if (flag_set) begin
			warning_irq_flag <= 1'b1; // [R10]
		end else if (wr_flags && pwdata_in[0]) begin
			warning_irq_flag <= 1'b0; // [R18]
		end
	end

	// below indication synchroniser and previous sample
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			below_meta <= 1'b0;
			below_sync <= 1'b0;
			below_prev <= 1'b0;
		end else begin
			below_meta <= below_threshold_in;
			below_sync <= below_meta; // [R19]
			below_prev <= below_sync;
		end
	end

	// power state follows the synchronised sleep request
	logic sleep_meta;
	logic sleep_sync;
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			sleep_meta <= 1'b0;
			sleep_sync <= 1'b0;
		end else begin
			sleep_meta <= deep_sleep_in;
			sleep_sync <= sleep_meta;
		end
	end

	always_comb begin
		case (pwr_state)
			smr_pkg::SMR_AWAKE:  next_pwr_state = sleep_sync ? smr_pkg::SMR_ASLEEP : smr_pkg::SMR_AWAKE;
			smr_pkg::SMR_ASLEEP: next_pwr_state = sleep_sync ? smr_pkg::SMR_ASLEEP : smr_pkg::SMR_AWAKE;
			default:             next_pwr_state = smr_pkg::SMR_AWAKE;
		endcase
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			pwr_state <= smr_pkg::SMR_AWAKE;
		end else begin
			pwr_state <= next_pwr_state; // [R15]
		end
	end

	// execution hold after wake in the continuous-hold mode
	logic run_meta;
	logic run_sync;
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			run_meta  <= 1'b0;
			run_sync  <= 1'b0;
			hold_exec <= 1'b0;
		end else begin
			run_meta <= detector_running_in;
			run_sync <= run_meta;
			if (pwr_state == smr_pkg::SMR_ASLEEP && next_pwr_state == smr_pkg::SMR_AWAKE &&
				active_mode == smr_pkg::MODE_CONT_HOLD) begin
				hold_exec <= 1'b1; // [R3]
			end else if (run_sync) begin
				hold_exec <= 1'b0; // [R3]
			end
		end
	end

	assign detector_mode_out           = eff_mode; // [R15]
	assign detector_sampled_out        = (eff_mode == smr_pkg::MODE_SAMPLED); // [R3] [R16]
	assign sampling_rate_sel_out       = sampling_rate_sel; // [R1]
	assign threshold_level_out         = threshold_level;
	assign warning_margin_out          = warning_margin;
	assign monitor_enable_out          = mon_on; // [R16]
	assign continuous_hold_on_wake_out = hold_exec;
	assign irq_out                     = warning_irq_en && warning_irq_flag; // [R17]

	// multi-step behaviours shared by the checks below
	sequence s_below_held;
		below_threshold_in ##1 below_threshold_in;
	endsequence
	sequence s_waking;
		(pwr_state == smr_pkg::SMR_ASLEEP) ##1 (pwr_state == smr_pkg::SMR_AWAKE);
	endsequence

	a_flag_sets_on_edge: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R10]
		flag_set |=> warning_irq_flag)
		else $error("flag did not set on matching crossing");
	a_flag_frozen_off: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R11]
		(!det_on && !(wr_flags && pwdata_in[0])) |=> $stable(warning_irq_flag))
		else $error("flag changed while detector off");
	a_flag_w1c: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R18]
		(wr_flags && pwdata_in[0] && !flag_set) |=> !warning_irq_flag)
		else $error("flag not cleared by write of one");
	a_irq_level: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R17]
		irq_out == (warning_irq_en && warning_irq_flag))
		else $error("irq does not match enable and flag");
	a_sleep_locked: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R14]
		(fuse_loaded && wr_mode && !unlocked) |=> $stable(sleep_mode))
		else $error("sleep field written without unlock");
	a_sleep_no_rsvd: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R5]
		fuse_loaded && $past(fuse_loaded) && $changed(sleep_mode) |-> sleep_mode != 2'h3)
		else $error("reserved sleep mode accepted");
	a_active_ro: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R2]
		fuse_loaded |=> $stable(active_mode) && $stable(threshold_level))
		else $error("read-only field changed");
	a_status_lag: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R19]
		s_below_held |=> below_sync)
		else $error("below indication not synchronised in two cycles");
	a_mode_sleep: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R15]
		detector_mode_out == ((pwr_state == smr_pkg::SMR_ASLEEP) ? sleep_mode : active_mode))
		else $error("wrong detector mode for power state");
	a_mon_off: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R16]
		(detector_mode_out == smr_pkg::MODE_OFF) |-> !monitor_enable_out)
		else $error("monitor on while detector off");

	// protection window, interrupt hold, flag cause, reserved edge, wake hold and fuse capture
	a_sleep_unlocked: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R14]
		(fuse_loaded && wr_mode && unlocked && (wr_sleep != smr_pkg::MODE_CONT_HOLD)) |=>
		(sleep_mode == $past(wr_sleep)))
		else $error("unlocked sleep field write lost");
	a_unlock_expire: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R14]
		((unlock_count == 3'h1) && wr_done && !key_ok && !wr_mode) |=> !unlocked)
		else $error("unlock window outlived its writes");
	a_irq_holds: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R17]
		(irq_out && !wr_flags && !wr_irqctl) |=> irq_out)
		else $error("interrupt request dropped before flag clear");
	a_flag_cause: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R10]
		$rose(warning_irq_flag) |-> $past(flag_set))
		else $error("flag set without a matching crossing");
	a_edge_rsvd: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R8]
		(warning_edge_sel == 2'h3) |=> !$rose(warning_irq_flag))
		else $error("reserved edge selection set the flag");
	a_hold_on_wake: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R3]
		(s_waking ##0 (active_mode == smr_pkg::MODE_CONT_HOLD)) |-> hold_exec)
		else $error("execution not held after wake in hold mode");
	a_hold_release: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R3]
		(hold_exec && run_sync && (pwr_state == smr_pkg::SMR_AWAKE)) |=> !hold_exec)
		else $error("execution hold kept after detector runs");
	a_fuse_capture: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R1] [R6]
		$rose(fuse_loaded) |-> (threshold_level == $past(fuse_level_in)) &&
		(active_mode == $past(fuse_active_mode_in)) && (sleep_mode == $past(fuse_sleep_mode_in)) &&
		(sampling_rate_sel == $past(fuse_samp_rate_in)))
		else $error("fuse values not captured after reset");
endmodule

// File: smr_analog_model.sv
// analog comparator and fuse loader model for the supply monitor registers
`timescale 1ns/100ps
module smr_analog_model (
	// control from bench and block
	input  wire logic       core_clk_in,
	input  wire logic       fuse_alt_in,
	input  wire logic       supply_low_in,
	input  wire logic       monitor_enable_in,
	input  wire logic [1:0] detector_mode_in,
	// fuse values and comparator outputs
	output logic            fuse_samp_rate_out,
	output logic      [1:0] fuse_active_mode_out,
	output logic      [1:0] fuse_sleep_mode_out,
	output logic      [2:0] fuse_level_out,
	output logic            below_threshold_out,
	output logic            detector_running_out
);
	logic idle_pat = 1'b0;
	// second fuse set, chosen across a mid-run reset, selects the hold-on-wake mode
	assign fuse_samp_rate_out   = fuse_alt_in ? 1'b0 : 1'b1;
	assign fuse_active_mode_out = fuse_alt_in ? 2'h3 : 2'h1;
	assign fuse_sleep_mode_out  = fuse_alt_in ? 2'h2 : 2'h1;
	assign fuse_level_out       = fuse_alt_in ? 3'h0 : 3'h2;
	always @(posedge core_clk_in) begin
		idle_pat <= ~idle_pat;
		detector_running_out <= (detector_mode_in != 2'h0);
	end
	// comparator output is junk while the monitor is off
	assign below_threshold_out = monitor_enable_in ? supply_low_in : idle_pat;
endmodule

// File: smr_supply_monitor_regs_tb.sv
// self-checking bench for the supply monitor register block
`timescale 1ns/100ps
module smr_supply_monitor_regs_tb;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        deep_sleep = 1'b0;
	logic        supply_low = 1'b0;
	logic        fuse_alt = 1'b0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, irq, mon_en, samp, rate_f, below, run, err, hold, rate_o;
	logic [1:0]  det_mode, act_f, slp_f, margin_o;
	logic [2:0]  lvl_f, lvl_o;
	int          num_errors = 0;
	int          comparisons = 0;
	int          cycles = 0;

	smr_supply_monitor_regs i_dut (.core_clk_in(core_clk), .rst_in(rst),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .pstrb_in(4'hF), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .fuse_samp_rate_in(rate_f), .fuse_active_mode_in(act_f),
		.fuse_sleep_mode_in(slp_f), .fuse_level_in(lvl_f), .deep_sleep_in(deep_sleep),
		.below_threshold_in(below), .detector_running_in(run),
		.detector_mode_out(det_mode), .detector_sampled_out(samp),
		.sampling_rate_sel_out(rate_o), .threshold_level_out(lvl_o), .warning_margin_out(margin_o),
		.monitor_enable_out(mon_en), .continuous_hold_on_wake_out(hold), .irq_out(irq));
	smr_analog_model i_far (.core_clk_in(core_clk), .supply_low_in(supply_low),
		.fuse_alt_in(fuse_alt),
		.monitor_enable_in(mon_en), .detector_mode_in(det_mode),
		.fuse_samp_rate_out(rate_f), .fuse_active_mode_out(act_f),
		.fuse_sleep_mode_out(slp_f), .fuse_level_out(lvl_f),
		.below_threshold_out(below), .detector_running_out(run));

	initial forever #5 core_clk = ~core_clk;

	task give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			num_errors++;
			give_verdict;
		end
	end

	task wt(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	task wr(input logic [3:0] i, input logic [7:0] d);
		xfer(1'b1, {2'b00, i, 2'b00}, d);
	endtask

	task rchk(input string n, input logic [3:0] i, input logic [31:0] e);
		xfer(1'b0, {2'b00, i, 2'b00}, 8'h00);
		chk(n, e, rd);
	endtask

	task unlock;
		wr(smr_pkg::IDX_UNLOCK, smr_pkg::IO_REGISTER_UNLOCK_KEY);
	endtask

	task t_reset;
		rchk("mode", smr_pkg::IDX_MODE_CTRL, 32'h15);
		rchk("level", smr_pkg::IDX_LEVEL_SEL, 32'h02);
		rchk("margin", smr_pkg::IDX_MARGIN_CTRL, 32'h00);
		rchk("irqctl", smr_pkg::IDX_IRQ_CTRL, 32'h00);
		rchk("flags", smr_pkg::IDX_IRQ_FLAGS, 32'h00);
		chk("mon_en", 32'h0, mon_en);
		chk("rate_out", 32'h1, rate_o);
		chk("level_out", 32'h2, lvl_o);
		wr(smr_pkg::IDX_MODE_CTRL, 8'hFF);
		rchk("mode_locked", smr_pkg::IDX_MODE_CTRL, 32'h15);
		$display("test reset done");
	endtask

	task t_unlock;
		unlock;
		wr(smr_pkg::IDX_MODE_CTRL, 8'h0E);
		rchk("sleep_set", smr_pkg::IDX_MODE_CTRL, 32'h16);
		unlock;
		wr(smr_pkg::IDX_MODE_CTRL, 8'h03);
		rchk("sleep_rsvd", smr_pkg::IDX_MODE_CTRL, 32'h16);
		deep_sleep <= 1'b1;
		wt(5);
		chk("sampled", 32'h1, samp);
		chk("mode_sleep", 32'h2, det_mode);
		deep_sleep <= 1'b0;
		wt(5);
		chk("mode_wake", 32'h1, det_mode);
		unlock;
		repeat (3) wr(smr_pkg::IDX_MARGIN_CTRL, 8'h00);
		wr(smr_pkg::IDX_MODE_CTRL, 8'h01);
		rchk("window_last", smr_pkg::IDX_MODE_CTRL, 32'h15);
		unlock;
		repeat (4) wr(smr_pkg::IDX_MARGIN_CTRL, 8'h00);
		wr(smr_pkg::IDX_MODE_CTRL, 8'h00);
		rchk("window_over", smr_pkg::IDX_MODE_CTRL, 32'h15);
		$display("test unlock done");
	endtask

	task t_edges;
		wr(smr_pkg::IDX_MARGIN_CTRL, 8'h01);
		wt(1);
		chk("mon_on", 32'h1, mon_en);
		chk("margin_out", 32'h1, margin_o);
		for (int e = 0; e < 4; e++) begin
			wr(smr_pkg::IDX_IRQ_CTRL, {5'h0, e[1:0], 1'b1});
			wt(6);
			wr(smr_pkg::IDX_IRQ_FLAGS, 8'h01);
			supply_low <= 1'b1;
			wt(6);
			rchk("status", smr_pkg::IDX_STATUS, 32'h1);
			rchk("flag_fall", smr_pkg::IDX_IRQ_FLAGS, e == 0 || e == 2);
			chk("irq_fall", e == 0 || e == 2, irq);
			wr(smr_pkg::IDX_IRQ_FLAGS, 8'h00);
			rchk("flag_keep", smr_pkg::IDX_IRQ_FLAGS, e == 0 || e == 2);
			wr(smr_pkg::IDX_IRQ_FLAGS, 8'h01);
			supply_low <= 1'b0;
			wt(6);
			rchk("flag_rise", smr_pkg::IDX_IRQ_FLAGS, e == 1 || e == 2);
			wr(smr_pkg::IDX_IRQ_CTRL, {5'h0, e[1:0], 1'b0});
			wt(1);
			chk("irq_masked", 32'h0, irq);
			wr(smr_pkg::IDX_IRQ_FLAGS, 8'h01);
			rchk("flag_clr", smr_pkg::IDX_IRQ_FLAGS, 32'h0);
		end
		$display("test edges done");
	endtask

	task t_sleep_off;
		wr(smr_pkg::IDX_IRQ_CTRL, 8'h05);
		unlock;
		wr(smr_pkg::IDX_MODE_CTRL, 8'h00);
		deep_sleep <= 1'b1;
		wt(5);
		wr(smr_pkg::IDX_IRQ_FLAGS, 8'h01);
		chk("mode_off", 32'h0, det_mode);
		chk("mon_off", 32'h0, mon_en);
		supply_low <= 1'b1;
		wt(6);
		rchk("flag_frozen", smr_pkg::IDX_IRQ_FLAGS, 32'h0);
		deep_sleep <= 1'b0;
		wt(5);
		$display("test sleep_off done");
	endtask

	task t_unmapped;
		xfer(1'b0, 8'h08, 8'h00);
		chk("err_hole", 32'h1, err);
		chk("rd_hole", 32'h0, rd);
		xfer(1'b1, 8'h21, 8'h03);
		chk("err_align", 32'h1, err);
		rchk("margin_kept", smr_pkg::IDX_MARGIN_CTRL, 32'h1);
		$display("test unmapped done");
	endtask

	task t_hold;
		supply_low <= 1'b0;
		rst <= 1'b1;
		fuse_alt <= 1'b1;
		wt(4);
		rst <= 1'b0;
		wt(2);
		rchk("mode_alt", smr_pkg::IDX_MODE_CTRL, 32'h0E);
		rchk("level_alt", smr_pkg::IDX_LEVEL_SEL, 32'h00);
		rchk("margin_rst", smr_pkg::IDX_MARGIN_CTRL, 32'h00);
		rchk("flags_rst", smr_pkg::IDX_IRQ_FLAGS, 32'h00);
		chk("rate_alt", 32'h0, rate_o);
		chk("hold_idle", 32'h0, hold);
		unlock;
		wr(smr_pkg::IDX_MODE_CTRL, 8'h00);
		rchk("sleep_off_alt", smr_pkg::IDX_MODE_CTRL, 32'h0C);
		deep_sleep <= 1'b1;
		wt(8);
		chk("mode_sleep_off", 32'h0, det_mode);
		deep_sleep <= 1'b0;
		wt(5);
		chk("hold_wake", 32'h1, hold);
		chk("mode_hold", 32'h3, det_mode);
		wt(4);
		chk("hold_done", 32'h0, hold);
		$display("test hold done");
	endtask

	initial begin
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		wt(2);
		t_reset;
		t_unlock;
		t_edges;
		t_sleep_off;
		t_unmapped;
		t_hold;
		give_verdict;
	end
endmodule
